// file: hw/iet_top.sv
// Purpose : Prioritised interrupt controller with eight event transfer channels
// Assumes : CPU reports its current level and acknowledges offered interrupts
// Notes   : APB slave answers every access with one wait state
//
// Local design decisions: register access over APB and the register offsets.

// Function
// R1 - Interrupt offered 7 or 11 clocks later
// R2 - Per node choice: vector or transfer
// R3 - Standard service branches CPU to vector
// R4 - Transfer steals exactly one CPU cycle
// R5 - Move byte/word, then step pointers
// R6 - Counter decrements unless continuous mode
// R7 - Counter zero raises the node's interrupt
// R8 - Eight independent transfer channels
// R9 - Node register: request, enable, priority
// R10 - Sixteen priority levels per node
// R11 - Preempt only with strictly higher level
// R12 - Each node has its own vector
// R13 - External edges: rising, falling or both
// R14 - Trap instruction selects vector by number
// R15 - Software may set request bits
// R16 - Vector offset is four times trap
// R17 - Nodes 16..29 select alternative source; code: nodes 0..13 (traps 16..29)
// R18 - Eight converter nodes from trap 28h
// R19 - Segment register and spacing field
// R20 - Highest pending wins, flag cleared
// R21 - Disabled node stays pending, not served
module iet_top
	import iet_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [31:0] periph_req,
	input  wire logic [5:0]  serial_req,
	input  wire logic [3:0]  ext_pin,
	input  wire logic        trap_valid,
	input  wire logic [6:0]  trap_num,
	input  wire logic [3:0]  cpu_level,
	input  wire logic        irq_ack,
	output logic             irq_valid,
	output logic      [23:0] irq_vector,
	output logic      [3:0]  irq_level,
	output logic             cpu_steal,
	output logic             xfer_valid,
	output logic      [23:0] xfer_src,
	output logic      [23:0] xfer_dst,
	output logic             xfer_word
);

	// ********************************************************
	// Register bus
	// ********************************************************
	logic        pready_q;
	logic [31:0] prdata_q;
	logic        pslverr_q;
	logic        apb_wr;
	logic        hit;
	logic [31:0] rd_mux;
	logic [2:0]  ctrl_q;
	logic [7:0]  vseg_q;
	logic [7:0]  edge_q;
	logic [15:0] node_q [NODES];
	logic        node_page;
	logic        chan_page;

	assign node_page = paddr[11:7] == NODE_PAGE;
	assign chan_page = paddr[11:7] == CHAN_PAGE;
	// A write lands only on the edge where the master sees pready
	assign apb_wr    = psel && penable && pwrite && pready_q;

	// ********************************************************
	// Channel wiring
	// ********************************************************
	iet_chan_if  cif [CHANS] ();
	logic [23:0] c_src [CHANS];
	logic [23:0] c_dst [CHANS];
	logic [7:0]  c_cnt [CHANS];
	logic [3:0]  c_cfg [CHANS];
	logic [CHANS-1:0] fire;

	genvar g;
	generate
		for (g = 0; g < CHANS; g++) begin : gen_ch
			assign cif[g].wr_en  = apb_wr && chan_page && paddr[6:4] == 3'(g);
			assign cif[g].wr_sel = paddr[3:2];
			assign cif[g].wdata  = pwdata;
			assign cif[g].fire   = fire[g];
			assign c_src[g]      = cif[g].src;
			assign c_dst[g]      = cif[g].dst;
			assign c_cnt[g]      = cif[g].count;
			assign c_cfg[g]      = cif[g].cfg;
			iet_chan u_chan ( // R8
				.pclk    (pclk),
				.presetn (presetn),
				.bus     (cif[g])
			);
		end
	endgenerate

	// Read multiplexer; unmapped addresses read zero and flag an error
	iet_state_t state_q;
	logic       trap_pend_q;
	logic       win;
	logic [4:0] win_idx;
	always_comb begin
		rd_mux = 32'h00000000;
		hit    = 1'b1;
		if (node_page) begin
			rd_mux = {16'h0000, node_q[paddr[6:2]]};
		end else if (chan_page) begin
			case (paddr[3:2])
				CH_SRC:  rd_mux = {8'h00, c_src[paddr[6:4]]};
				CH_DST:  rd_mux = {8'h00, c_dst[paddr[6:4]]};
				CH_CNT:  rd_mux = {24'h000000, c_cnt[paddr[6:4]]};
				default: rd_mux = {28'h0000000, c_cfg[paddr[6:4]]};
			endcase
		end else begin
			case (paddr)
				OFF_CTRL: rd_mux = {29'h0000000, ctrl_q};
				OFF_VSEG: rd_mux = {24'h000000, vseg_q};
				OFF_STAT: rd_mux = {23'h000000, state_q, trap_pend_q, win, win_idx};
				OFF_EDGE: rd_mux = {24'h000000, edge_q};
				default:  hit    = 1'b0;
			endcase
		end
	end

	// One wait state keeps every bus output on a flip-flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			prdata_q  <= 32'h00000000;
			pslverr_q <= 1'b0;
		end else if (psel && penable && !pready_q) begin
			pready_q  <= 1'b1;
			prdata_q  <= pwrite ? 32'h00000000 : rd_mux;
			pslverr_q <= !hit;
		end else begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end
	end

	// Global configuration: jump cache, spacing, segment, edges
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= CTRL_RST;
			vseg_q <= VSEG_RST;
			edge_q <= EDGE_RST;
		end else if (apb_wr && !node_page && !chan_page) begin
			if (paddr == OFF_CTRL) ctrl_q <= pwdata[2:0];
			if (paddr == OFF_VSEG) vseg_q <= pwdata[7:0]; // R19
			if (paddr == OFF_EDGE) edge_q <= pwdata[7:0];
		end
	end

	// ********************************************************
	// External edge detection
	// ********************************************************
	logic [EXT_PINS-1:0] ext_s1_q;
	logic [EXT_PINS-1:0] ext_s2_q;
	logic [EXT_PINS-1:0] ext_s3_q;
	logic [EXT_PINS-1:0] ext_evt;

	// Pins are asynchronous; the second and third stages feed the detector
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_s1_q <= '0;
			ext_s2_q <= '0;
			ext_s3_q <= '0;
		end else begin
			ext_s1_q <= ext_pin;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
		end
	end

	always_comb begin
		for (int k = 0; k < EXT_PINS; k++) begin
			ext_evt[k] = (edge_q[2*k]   &&  ext_s2_q[k] && !ext_s3_q[k])
			          || (edge_q[2*k+1] && !ext_s2_q[k] &&  ext_s3_q[k]); // R13
		end
	end

	// ********************************************************
	// Request sources per node
	// ********************************************************
	logic [NODES-1:0] src_evt;
	logic [ALT_NODES-1:0] alt_src;

	// Nodes 0-3 and 8-11 share the external unit, the rest serial channels
	always_comb begin
		// A fixed concatenation keeps every index in range
		alt_src = {serial_req[5:4], ext_evt, serial_req[3:0], ext_evt};
		src_evt = periph_req;
		for (int k = 0; k < ALT_NODES; k++) begin
			if (node_q[k][NB_ALT]) src_evt[k] = alt_src[k]; // R17
		end
	end

	// ********************************************************
	// Arbitration
	// ********************************************************
	logic [3:0]  best;
	logic [15:0] wnode;
	logic [2:0]  wch;
	logic        etc_go;
	logic        keep_req;
	logic        take_node;
	logic        take_trap;
	logic [NODES-1:0] clr_req;

	// Strictly-greater compare keeps the lowest index among equals
	always_comb begin
		best    = cpu_level;
		win     = 1'b0;
		win_idx = 5'h00;
		for (int k = 0; k < NODES; k++) begin
			if (node_q[k][NB_REQ] && node_q[k][NB_EN] // R21
			    && node_q[k][NB_LVL +: 4] > best) begin // R10 R11
				best    = node_q[k][NB_LVL +: 4];
				win     = 1'b1;
				win_idx = 5'(k); // R20
			end
		end
	end

	assign wnode = node_q[win_idx];
	assign wch   = wnode[NB_CH +: 3];
	// An exhausted non-continuous channel falls back to the vector
	assign etc_go    = wnode[NB_ETC]
	                && !(c_cnt[wch] == 8'h00 && !c_cfg[wch][CB_CONT]); // R2 R7
	assign take_trap = state_q == ST_IDLE && trap_pend_q;
	assign take_node = state_q == ST_IDLE && !trap_pend_q && win;
	// Last counted move leaves the flag set so the vector follows
	assign keep_req  = etc_go && c_cnt[wch] == 8'h01 && !c_cfg[wch][CB_CONT]; // R7

	always_comb begin
		clr_req = '0;
		fire    = '0;
		if (take_node && !keep_req) clr_req[win_idx] = 1'b1; // R20
		if (take_node && etc_go) fire[wch] = 1'b1;
	end

	// Node control registers; hardware set wins over any clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int k = 0; k < NODES; k++) node_q[k] <= NODE_RST;
		end else begin
			for (int k = 0; k < NODES; k++) begin
				if (apb_wr && node_page && paddr[6:2] == 5'(k)) begin
					node_q[k][8:0]   <= pwdata[8:0]; // R9
					node_q[k][NB_EN] <= pwdata[NB_EN];
					node_q[k][NB_REQ] <= pwdata[NB_REQ] || src_evt[k]; // R15
				end else if (src_evt[k]) begin
					node_q[k][NB_REQ] <= 1'b1;
				end else if (clr_req[k]) begin
					node_q[k][NB_REQ] <= 1'b0;
				end
			end
		end
	end

	// Pending trap; a new trap in the cycle of taking re-arms it
	logic [6:0] trap_num_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trap_pend_q <= 1'b0;
			trap_num_q  <= 7'h00;
		end else if (trap_valid) begin
			trap_pend_q <= 1'b1;
			trap_num_q  <= trap_num; // R14
		end else if (take_trap) begin
			trap_pend_q <= 1'b0;
		end
	end

	// ********************************************************
	// Vector and service sequencing
	// ********************************************************
	logic [6:0]  svc_trap;
	logic [15:0] vec_off;
	logic [3:0]  resp;
	logic [3:0]  cnt_q;

	assign svc_trap = take_trap ? trap_num_q : 7'(TRAP_BASE + 7'(win_idx)); // R12 R18
	// Offset is trap times four, widened by the spacing field
	assign vec_off  = {7'h00, svc_trap, 2'h0} << ctrl_q[CTL_SC +: 2]; // R16 R19
	assign resp     = ctrl_q[CTL_JC] ? RESP_JC : RESP_NOJC;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q    <= ST_IDLE;
			cnt_q      <= 4'h0;
			irq_valid  <= 1'b0;
			irq_vector <= 24'h000000;
			irq_level  <= 4'h0;
			cpu_steal  <= 1'b0;
			xfer_valid <= 1'b0;
			xfer_src   <= 24'h000000;
			xfer_dst   <= 24'h000000;
			xfer_word  <= 1'b0;
		end else begin
			cpu_steal  <= 1'b0;
			xfer_valid <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					if (take_trap || (take_node && !etc_go)) begin
						irq_vector <= {vseg_q, vec_off}; // R3
						irq_level  <= take_trap ? cpu_level : best;
						cnt_q      <= resp;
						state_q    <= ST_WAIT;
					end else if (take_node) begin
						cpu_steal  <= 1'b1; // R4
						xfer_valid <= 1'b1;
						xfer_src   <= c_src[wch]; // R5
						xfer_dst   <= c_dst[wch];
						xfer_word  <= c_cfg[wch][CB_WORD];
						state_q    <= ST_MOVE;
					end
				end
				ST_WAIT: begin
					cnt_q <= cnt_q - 4'h1;
					if (cnt_q == 4'h1) begin
						irq_valid <= 1'b1; // R1
						state_q   <= ST_OFFER;
					end
				end
				ST_OFFER: begin
					// Held until the CPU takes it and raises its level
					if (irq_ack) begin
						irq_valid <= 1'b0;
						state_q   <= ST_IDLE;
					end
				end
				ST_MOVE: begin
					state_q <= ST_IDLE;
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;

endmodule : iet_top

// file: hw/iet_pkg.sv
// Purpose : Shared constants and types of the interrupt and event transfer block
// Assumes : One clock domain (pclk), registers reached over APB
// Notes   : Every offset, field position and count lives here, and the reset values of node and global registers

package iet_pkg;

	// ********************************************************
	// Sizes
	// ********************************************************
	localparam int         NODES      = 32;      // Nodes with trap numbers 10h..2Fh
	localparam int         CHANS      = 8;       // Event transfer channels
	localparam int         ALT_NODES  = 14;      // Nodes 0..13 (traps 16..29) have an alternative source
	localparam int         EXT_PINS   = 4;       // Fast external request inputs
	localparam int         SER_REQS   = 6;       // Serial channel alternative requests
	localparam logic [6:0] TRAP_BASE  = 7'h10;   // Trap number of node 0
	localparam logic [6:0] ADC_TRAP   = 7'h28;   // Trap number of first converter node

	// ********************************************************
	// Register offsets (byte addresses)
	// ********************************************************
	localparam logic [11:0] OFF_CTRL  = 12'h000;
	localparam logic [11:0] OFF_VSEG  = 12'h004;
	localparam logic [11:0] OFF_STAT  = 12'h008;
	localparam logic [11:0] OFF_EDGE  = 12'h00C;
	localparam logic [4:0]  NODE_PAGE = 5'h02;   // paddr[11:7] of 0x100..0x17C
	localparam logic [4:0]  CHAN_PAGE = 5'h04;   // paddr[11:7] of 0x200..0x27C

	// ********************************************************
	// Field positions
	// ********************************************************
	localparam int NB_LVL = 0;   // [3:0] priority level
	localparam int NB_ETC = 4;   // Serve by event transfer
	localparam int NB_CH  = 5;   // [7:5] channel select
	localparam int NB_ALT = 8;   // Use alternative source
	localparam int NB_EN  = 14;  // Enable
	localparam int NB_REQ = 15;  // Request flag
	localparam int CB_WORD = 0;  // Word move, else byte
	localparam int CB_INCS = 1;  // Increment source pointer
	localparam int CB_INCD = 2;  // Increment destination pointer
	localparam int CB_CONT = 3;  // Continuous mode, counter frozen
	localparam int CTL_JC  = 0;  // Jump cache in use
	localparam int CTL_SC  = 1;  // [2:1] vector spacing field

	localparam logic [1:0] CH_SRC = 2'h0;
	localparam logic [1:0] CH_DST = 2'h1;
	localparam logic [1:0] CH_CNT = 2'h2;
	localparam logic [1:0] CH_CFG = 2'h3;

	// ********************************************************
	// Reset values and timing
	// ********************************************************
	localparam logic [7:0]  VSEG_RST = 8'h00;
	localparam logic [2:0]  CTRL_RST = 3'h0;   // Spacing 4 bytes, no jump cache
	localparam logic [15:0] NODE_RST = 16'h0000;
	localparam logic [7:0]  EDGE_RST = 8'h00;
	localparam logic [3:0]  RESP_JC   = 4'h7;  // Response clocks with jump cache
	localparam logic [3:0]  RESP_NOJC = 4'hB;  // Response clocks without it

	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_OFFER, ST_MOVE} iet_state_t;

endpackage : iet_pkg

// file: hw/iet_chan_if.sv
// Purpose : Control and state of one event transfer channel
// Assumes : Driven by the controller, answered by one channel
// Notes   : No clocking; all signals are pclk synchronous

interface iet_chan_if;
	logic        wr_en;
	logic [1:0]  wr_sel;
	logic [31:0] wdata;
	logic        fire;
	logic [23:0] src;
	logic [23:0] dst;
	logic [7:0]  count;
	logic [3:0]  cfg;

	modport ctl  (output wr_en, wr_sel, wdata, fire, input src, dst, count, cfg);
	modport chan (input wr_en, wr_sel, wdata, fire, output src, dst, count, cfg);
endinterface : iet_chan_if

// file: hw/iet_chan.sv
// Purpose : One event transfer channel: pointers, counter, mode
// Assumes : fire is a one-cycle pulse in the cycle the move is issued
// Notes   : A software write wins over a step in the same cycle

module iet_chan
	import iet_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	iet_chan_if.chan bus
);

	logic [23:0] step;

	// Byte moves step by one, word moves by two
	assign step = bus.cfg[CB_WORD] ? 24'h000002 : 24'h000001;

	// Source pointer, stepped after the move when enabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus.src <= 24'h000000;
		end else if (bus.wr_en && bus.wr_sel == CH_SRC) begin
			bus.src <= bus.wdata[23:0];
		end else if (bus.fire && bus.cfg[CB_INCS]) begin
			bus.src <= bus.src + step; // R5
		end
	end

	// Destination pointer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus.dst <= 24'h000000;
		end else if (bus.wr_en && bus.wr_sel == CH_DST) begin
			bus.dst <= bus.wdata[23:0];
		end else if (bus.fire && bus.cfg[CB_INCD]) begin
			bus.dst <= bus.dst + step; // R5
		end
	end

	// Transfer counter, frozen in continuous mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus.count <= 8'h00;
		end else if (bus.wr_en && bus.wr_sel == CH_CNT) begin
			bus.count <= bus.wdata[7:0];
		end else if (bus.fire && !bus.cfg[CB_CONT] && bus.count != 8'h00) begin
			bus.count <= bus.count - 8'h01; // R6
		end
	end

	// Mode bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus.cfg <= 4'h0;
		end else if (bus.wr_en && bus.wr_sel == CH_CFG) begin
			bus.cfg <= bus.wdata[3:0];
		end
	end

endmodule : iet_chan

// file: sim/iet_assertions.sv
// Purpose: Port-level checks of iet_top
// Assumes: One pclk domain, presetn async low
// Notes: Bound into every iet_top
module iet_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        irq_ack,
	input wire logic        irq_valid,
	input wire logic [23:0] irq_vector,
	input wire logic [3:0]  irq_level,
	input wire logic        cpu_steal,
	input wire logic        xfer_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****
	// Checks
	// ****
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_apb_wait; psel && penable && !pready |=> pready; endproperty
	a_apb_wait: assert property (p_apb_wait) else $error("pready late");
	property p_apb_one; pready |=> !pready; endproperty
	a_apb_one: assert property (p_apb_one) else $error("pready too long");
	property p_slverr; pslverr |-> pready && $past(psel && penable); endproperty
	a_slverr: assert property (p_slverr) else $error("stray pslverr");
	property p_irq_hold; irq_valid && !irq_ack |=> irq_valid && $stable(irq_vector) && $stable(irq_level); endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("offer not held");
	property p_irq_drop; irq_valid && irq_ack |=> !irq_valid; endproperty
	a_irq_drop: assert property (p_irq_drop) else $error("offer kept after ack");
	property p_steal; cpu_steal |-> xfer_valid ##1 !cpu_steal; endproperty
	a_steal: assert property (p_steal) else $error("steal not one cycle");
	property p_pair; xfer_valid |-> cpu_steal && !irq_valid; endproperty
	a_pair: assert property (p_pair) else $error("move without steal");
	property p_align; irq_valid |-> irq_vector[1:0] == 2'h0; endproperty
	a_align: assert property (p_align) else $error("vector not aligned");
	property p_quiet; $rose(irq_valid) |-> !$past(cpu_steal, 1) && !$past(cpu_steal, 2); endproperty
	a_quiet: assert property (p_quiet) else $error("offer right after move");
endmodule : iet_checker
bind iet_top iet_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pready(pready), .pslverr(pslverr), .irq_ack(irq_ack), .irq_valid(irq_valid), .irq_vector(irq_vector),
	.irq_level(irq_level), .cpu_steal(cpu_steal), .xfer_valid(xfer_valid));

// file: sim/iet_cpu_model.sv
// Purpose: CPU side: accepts offers and reports its level
// Assumes: Handler runs 40 clocks at the accepted level
// Notes: ack_wait sets prompt or slow acceptance
module iet_cpu_model (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       irq_valid,
	input  wire logic [3:0] irq_level,
	input  wire logic [2:0] ack_wait,
	output logic            irq_ack,
	output logic      [3:0] cpu_level
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] wait_q;
	logic [5:0] busy_q;
	// ****
	// Acceptance and handler level
	// ****
	// Level stays raised so lower or equal requests must wait
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_ack <= 1'b0;
			wait_q <= 4'h0;
			busy_q <= 6'h00;
			cpu_level <= 4'h0;
		end else begin
			irq_ack <= irq_valid && !irq_ack && wait_q == {1'b0, ack_wait};
			wait_q <= (irq_valid && !irq_ack) ? wait_q + 4'h1 : 4'h0;
			busy_q <= irq_ack ? 6'h28 : busy_q - 6'(busy_q != 6'h00);
			if (irq_ack) cpu_level <= irq_level;
			else if (busy_q == 6'h01) cpu_level <= 4'h0;
		end
	end
endmodule : iet_cpu_model

// file: sim/test_interrupt_and_event_transfer.sv
// Purpose: Self-checking bench of iet_top
// Assumes: One wait state APB, CPU model on the far side
// Notes: Results are matched in order against a queue
module test_interrupt_and_event_transfer;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, periph_req = 32'h0, prdata;
	logic [5:0]  serial_req = 6'h00;
	logic [3:0]  ext_pin = 4'h0, cpu_level, irq_level;
	logic        trap_valid = 1'b0, irq_ack, pready, pslverr, irq_valid, cpu_steal, xfer_valid, xfer_word, iv_q;
	logic [6:0]  trap_num = 7'h00;
	logic [23:0] irq_vector, xfer_src, xfer_dst;
	logic [2:0]  ack_wait = 3'h0;
	logic [1:0]  sc = 2'h0;
	logic [7:0]  vseg = 8'h12;
	logic [63:0] exp_q[$];
	integer      seed = 32'h41fa;
	int          fail_count = 0, samples_checked = 0;
	iet_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.periph_req(periph_req), .serial_req(serial_req), .ext_pin(ext_pin), .trap_valid(trap_valid),
		.trap_num(trap_num), .cpu_level(cpu_level), .irq_ack(irq_ack), .irq_valid(irq_valid),
		.irq_vector(irq_vector), .irq_level(irq_level), .cpu_steal(cpu_steal), .xfer_valid(xfer_valid),
		.xfer_src(xfer_src), .xfer_dst(xfer_dst), .xfer_word(xfer_word));
	iet_cpu_model u_cpu (.pclk(pclk), .presetn(presetn), .irq_valid(irq_valid), .irq_level(irq_level),
		.ack_wait(ack_wait), .irq_ack(irq_ack), .cpu_level(cpu_level));
	// ****
	// Tasks
	// ****
	always #25 pclk = ~pclk;
	task check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task cmp(input string nm, input logic [63:0] seen);
		// An empty queue means an unexpected result
		check(nm, seen, exp_q.size() ? exp_q.pop_front() : ~seen);
	endtask : cmp
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int t;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		t = 0;
		do begin
			@(posedge pclk);
			t++;
		end while (pready !== 1'b1 && t < 20);
		if (t == 20) fail_count++;
		psel <= 1'b0;
		penable <= 1'b0;
		// One idle edge, so no strobe is assigned twice in a time step
		@(posedge pclk);
	endtask : apb
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task rd(input logic [11:0] a, input logic [32:0] e);
		exp_q.push_back({31'h0, e});
		apb(1'b0, a, 32'h0);
	endtask : rd
	task pulse(input int k);
		periph_req[k] <= 1'b1;
		@(posedge pclk);
		periph_req[k] <= 1'b0;
	endtask : pulse
	task wait_q();
		// Idle means nothing owed, no offer and the CPU back at level 0
		repeat (400) if (exp_q.size() != 0 || cpu_level !== 4'h0 || irq_valid !== 1'b0) @(posedge pclk);
		// Still busy after the limit counts as a hang
		if (exp_q.size() != 0 || cpu_level !== 4'h0 || irq_valid !== 1'b0) fail_count++;
		repeat (4) @(posedge pclk);
	endtask : wait_q
	function automatic logic [63:0] ev(input logic [6:0] tr, input logic [3:0] lv);
		return {36'h0, lv, vseg, 16'({7'h0, tr, 2'h0} << sc)};
	endfunction : ev
	task close_out();
		if (exp_q.size() != 0) fail_count++;
		$display("checked %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : close_out
	// Result monitor
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite) cmp("read", {31'h0, pslverr, prdata});
		if (irq_valid && !iv_q) cmp("vector", {36'h0, irq_level, irq_vector});
		if (xfer_valid || cpu_steal) cmp("move", {14'h0, cpu_steal, xfer_word, xfer_src, xfer_dst});
		iv_q <= irq_valid;
	end
	// Watchdog, far beyond the thousand or so clocks needed
	initial begin
		#1000000;
		fail_count++;
		close_out();
	end
	// ****
	// Scenarios
	// ****
	initial begin : main
		int k, c, n;
		logic [23:0] s, d;
		logic [11:0] b;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 4; i++) rd(12'(4 * i), 33'h0);
		rd(12'h17C, 33'h0);
		rd(12'h27C, 33'h0);
		rd(12'h180, 33'h1_0000_0000);
		wr(12'h004, 32'h12);
		rd(12'h004, 33'h12);
		for (int jc = 0; jc < 2; jc++) begin
			sc = 2'(jc * 2);
			ack_wait <= 3'($random(seed));
			wr(12'h000, 32'(jc * 5));
			k = $unsigned($random(seed)) % 24;
			wr(12'(256 + 4 * k), 32'h4003);
			exp_q.push_back(ev(7'(16 + k), 4'h3));
			pulse(k);
			n = 0;
			do begin
				@(posedge pclk);
				#1;
				n++;
			end while (irq_valid !== 1'b1 && n < 40);
			check("latency", 64'(n), jc ? 64'h8 : 64'hC);
			wait_q();
		end
		// Disabled node keeps its flag
		k = $unsigned($random(seed)) % 24;
		wr(12'(256 + 4 * k), 32'h0006);
		pulse(k);
		repeat (30) @(posedge pclk);
		rd(12'(256 + 4 * k), 33'h8006);
		exp_q.push_back(ev(7'(16 + k), 4'h6));
		wr(12'(256 + 4 * k), 32'hC006);
		wait_q();
		for (int i = 0; i < 2; i++) begin
			trap_num <= i ? 7'h28 : 7'(16 + $unsigned($random(seed)) % 32);
			trap_valid <= 1'b1;
			@(posedge pclk);
			exp_q.push_back(ev(trap_num, 4'h0));
			trap_valid <= 1'b0;
			wait_q();
		end
		// Equal level waits, strictly higher level goes first
		wr(12'h104, 32'hC005);
		exp_q.push_back(ev(7'h11, 4'h5));
		for (n = 0; n < 100 && cpu_level !== 4'h5; n++) @(posedge pclk);
		wr(12'h108, 32'hC005);
		wr(12'h10C, 32'hC009);
		exp_q.push_back(ev(7'h13, 4'h9));
		exp_q.push_back(ev(7'h12, 4'h5));
		wait_q();
		// Word moves until the counter runs out, then the vector
		c = $unsigned($random(seed)) % 8;
		b = 12'(512 + 16 * c);
		s = 24'($random(seed));
		d = 24'($random(seed));
		k = 20 + $unsigned($random(seed)) % 4;
		wr(b, 32'(s));
		wr(b + 12'h4, 32'(d));
		wr(b + 12'h8, 32'h2);
		wr(b + 12'hC, 32'h7);
		wr(12'(256 + 4 * k), 32'(32'h4012 | (c << 5)));
		exp_q.push_back({14'h0, 2'h3, s, d});
		pulse(k);
		repeat (6) @(posedge pclk);
		exp_q.push_back({14'h0, 2'h3, s + 24'h2, d + 24'h2});
		exp_q.push_back(ev(7'(16 + k), 4'h2));
		pulse(k);
		wait_q();
		rd(b + 12'h8, 33'h0);
		wr(b + 12'h8, 32'h3);
		wr(b + 12'hC, 32'hA);
		exp_q.push_back({14'h0, 2'h2, s + 24'h4, d + 24'h4});
		pulse(k);
		wait_q();
		rd(b, {9'h0, s + 24'h5});
		rd(b + 12'h4, {9'h0, d + 24'h4});
		rd(b + 12'h8, 33'h3);
		// External pin in each edge mode
		wr(12'h100, 32'h4104);
		for (int m = 1; m < 4; m++) begin
			wr(12'h00C, 32'(m));
			repeat (m == 3 ? 2 : 1) exp_q.push_back(ev(7'h10, 4'h4));
			ext_pin[0] <= 1'b1;
			repeat (30) @(posedge pclk);
			ext_pin[0] <= 1'b0;
			repeat (30) @(posedge pclk);
			wait_q();
		end
		wr(12'h110, 32'h4104);
		exp_q.push_back(ev(7'h14, 4'h4));
		serial_req[0] <= 1'b1;
		@(posedge pclk);
		serial_req[0] <= 1'b0;
		wait_q();
		close_out();
	end
endmodule : test_interrupt_and_event_transfer
